// *** core/ctm_pkg.sv ***
// Functional notes
// - comparator A and comparator P each raise their own match request
// - compare mode: pin goes high, low or toggles on a comparator A match
// - compare low-byte write fills shared buffer; high-byte write loads high and buffer
// - high-byte read returns high and latches low into buffer; low read returns buffer
// - sixteen-bit counter counts upward only, on the selected clock
// - comparator P matches upper counter byte; comparator A matches full counter
// - software cannot load counter; enable rising edge clears it to zero
// - counter clears on overflow or selected comparator match, raising its request
// - pause bit holds counter value; clearing it resumes from that value
// - clock select: sys/4, sys, high/16, high/64, subsidiary twice, two reserved
// - enable high runs counter; low stops it and counter keeps residual value
// - enable rising edge in compare or PWM mode returns pin to initial level
// - control register 0 bits 2 to 0 always read as zero
// - mode field: 00 compare output, 10 PWM, 11 timer, 01 undefined
// - clear select 0: P match or overflow; 1: A match; ignored in PWM
// - initial-level bit: pin level before match, or PWM active level
package ctm_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int PRE_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 3'h6;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ONE = 6'h01;
  localparam logic [2:0] RSVD_ZERO = 3'h0;
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TIMER = 2'b11
  } ctm_mode_e;
  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'b000,
    CTM_CK_SYS = 3'b001,
    CTM_CK_HIGH16 = 3'b010,
    CTM_CK_HIGH64 = 3'b011,
    CTM_CK_SUB_A = 3'b100,
    CTM_CK_SUB_B = 3'b101,
    CTM_CK_RSVD_A = 3'b110,
    CTM_CK_RSVD_B = 3'b111
  } ctm_clk_sel_e;
  typedef enum logic [1:0] {
    CTM_ACT_NONE = 2'b00,
    CTM_ACT_LOW = 2'b01,
    CTM_ACT_HIGH = 2'b10,
    CTM_ACT_TOGGLE = 2'b11
  } ctm_pin_act_e;
  typedef struct packed {
    logic count_pause;
    ctm_clk_sel_e count_clock_select;
    logic timer_enable_bit;
    logic [2:0] rsvd;
  } ctm_ctrl0_s;
  typedef struct packed {
    ctm_mode_e operating_mode_select;
    ctm_pin_act_e pin_action_select;
    logic output_initial_level;
    logic output_polarity;
    logic duty_period_swap;
    logic clear_source_select;
  } ctm_ctrl1_s;
endpackage

// *** core/ctm_top.sv ***
module ctm_top (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [ctm_pkg::ADDR_W-1:0] addr_in,
  input wire logic [ctm_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic subsidiary_clock_in,
  output logic [ctm_pkg::DATA_W-1:0] rdata_out,
  output logic compare_a_flag_out,
  output logic compare_p_flag_out,
  output logic timer_output_pin_out,
  output logic timer_output_pin_inverted_out
);
  ctm_pkg::ctm_ctrl0_s ctrl0_q;
  ctm_pkg::ctm_ctrl1_s ctrl1_q;
  logic [ctm_pkg::CNT_W-1:0] cnt_q;
  logic [ctm_pkg::CNT_W-1:0] cnt_d;
  logic [ctm_pkg::CNT_W-1:0] cnt_inc;
  logic [ctm_pkg::CNT_W-1:0] compare_a_value_q;
  logic [ctm_pkg::DATA_W-1:0] compare_p_value_q;
  logic [ctm_pkg::DATA_W-1:0] hold_buf_q;
  logic [ctm_pkg::DATA_W-1:0] rdata_q;
  logic [ctm_pkg::PRE_W-1:0] presc_q;
  logic sub_s1_q;
  logic sub_s2_q;
  logic sub_s3_q;
  logic sub_lvl_q;
  logic sub_tick;
  logic tick;
  logic adv;
  logic en_rise;
  logic match_a;
  logic match_p;
  logic clr_hit;
  logic pwm_act;
  logic pin_q;
  logic pin_d;
  logic pin_out_q;
  logic irq_a_q;
  logic irq_p_q;
  logic wr_ctrl0;
  logic is_pwm;

  assign wr_ctrl0 = wr_in && (addr_in == ctm_pkg::ADDR_CTRL0);
  assign en_rise = wr_ctrl0 && wdata_in[3] && !ctrl0_q.timer_enable_bit;
  assign is_pwm = (ctrl1_q.operating_mode_select == ctm_pkg::CTM_MODE_PWM);

  // control registers; reserved bits are never stored
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl0_q <= '0;
    end else if (wr_ctrl0) begin
      ctrl0_q <= ctm_pkg::ctm_ctrl0_s'(wdata_in);
      ctrl0_q.rsvd <= ctm_pkg::RSVD_ZERO;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl1_q <= '0;
    end else if (wr_in && (addr_in == ctm_pkg::ADDR_CTRL1)) begin
      ctrl1_q <= ctm_pkg::ctm_ctrl1_s'(wdata_in);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_p_value_q <= ctm_pkg::BYTE_ZERO;
    end else if (wr_in && (addr_in == ctm_pkg::ADDR_PERIOD)) begin
      compare_p_value_q <= wdata_in;
    end
  end

  // compare A high-byte write commits both halves at once
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_a_value_q <= ctm_pkg::CNT_ZERO;
    end else if (wr_in && (addr_in == ctm_pkg::ADDR_CMPA_HI)) begin
      compare_a_value_q <= {wdata_in, hold_buf_q};
    end
  end

  // one buffer is shared by all pairs, so interleaved accesses corrupt each other
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_buf_q <= ctm_pkg::BYTE_ZERO;
    end else if (wr_in && (addr_in == ctm_pkg::ADDR_CMPA_LO)) begin
      hold_buf_q <= wdata_in;
    end else if (rd_in && (addr_in == ctm_pkg::ADDR_CNT_HI)) begin
      hold_buf_q <= cnt_q[7:0];
    end else if (rd_in && (addr_in == ctm_pkg::ADDR_CMPA_HI)) begin
      hold_buf_q <= compare_a_value_q[7:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= ctm_pkg::BYTE_ZERO;
    end else if (rd_in) begin
      case (addr_in)
        ctm_pkg::ADDR_CTRL0: rdata_q <= {ctrl0_q[7:3], ctm_pkg::RSVD_ZERO};
        ctm_pkg::ADDR_CTRL1: rdata_q <= ctrl1_q;
        ctm_pkg::ADDR_CNT_LO: rdata_q <= hold_buf_q;
        ctm_pkg::ADDR_CNT_HI: rdata_q <= cnt_q[15:8];
        ctm_pkg::ADDR_CMPA_LO: rdata_q <= hold_buf_q;
        ctm_pkg::ADDR_CMPA_HI: rdata_q <= compare_a_value_q[15:8];
        ctm_pkg::ADDR_PERIOD: rdata_q <= compare_p_value_q;
        default: rdata_q <= ctm_pkg::BYTE_ZERO;
      endcase
    end else begin
      rdata_q <= ctm_pkg::BYTE_ZERO;
    end
  end
  assign rdata_out = rdata_q;

  // subsidiary clock: three flops, accepted once stages two and three agree
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
      sub_lvl_q <= 1'b0;
    end else begin
      sub_s1_q <= subsidiary_clock_in;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
      if (sub_s2_q == sub_s3_q) begin
        sub_lvl_q <= sub_s3_q;
      end
    end
  end
  assign sub_tick = (sub_s2_q == sub_s3_q) && sub_s3_q && !sub_lvl_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + ctm_pkg::PRE_ONE;
    end
  end

  always_comb begin
    case (ctrl0_q.count_clock_select)
      ctm_pkg::CTM_CK_SYS4: tick = &presc_q[1:0];
      ctm_pkg::CTM_CK_SYS: tick = 1'b1;
      ctm_pkg::CTM_CK_HIGH16: tick = &presc_q[3:0];
      ctm_pkg::CTM_CK_HIGH64: tick = &presc_q;
      ctm_pkg::CTM_CK_SUB_A: tick = sub_tick;
      ctm_pkg::CTM_CK_SUB_B: tick = sub_tick;
      default: tick = 1'b0;
    endcase
  end

  assign adv = tick && ctrl0_q.timer_enable_bit && !ctrl0_q.count_pause;
  assign cnt_inc = cnt_q + ctm_pkg::CNT_ONE;
  // a zero period matches at the wrap to zero, so overflow and P match coincide
  assign match_a = adv && (cnt_inc == compare_a_value_q);
  assign match_p = adv && (cnt_inc == {compare_p_value_q, ctm_pkg::BYTE_ZERO});

  always_comb begin
    if (is_pwm) begin
      clr_hit = ctrl1_q.duty_period_swap ? match_a : match_p;
    end else begin
      clr_hit = ctrl1_q.clear_source_select ? match_a : match_p;
    end
  end

  always_comb begin
    if (en_rise) begin
      cnt_d = ctm_pkg::CNT_ZERO;
    end else if (clr_hit) begin
      cnt_d = ctm_pkg::CNT_ZERO;
    end else if (adv) begin
      cnt_d = cnt_inc;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= ctm_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_a_q <= 1'b0;
      irq_p_q <= 1'b0;
    end else begin
      irq_a_q <= match_a;
      irq_p_q <= match_p;
    end
  end
  assign compare_a_flag_out = irq_a_q;
  assign compare_p_flag_out = irq_p_q;

  // duty comes from whichever comparator is not the period
  assign pwm_act = ctrl1_q.duty_period_swap ? (cnt_q[15:8] < compare_p_value_q) :
                   (cnt_q < compare_a_value_q);

  always_comb begin
    pin_d = pin_q;
    if (en_rise && (ctrl1_q.operating_mode_select == ctm_pkg::CTM_MODE_CMP || is_pwm)) begin
      pin_d = ctrl1_q.output_initial_level;
    end else if (ctrl1_q.operating_mode_select == ctm_pkg::CTM_MODE_CMP && match_a) begin
      case (ctrl1_q.pin_action_select)
        ctm_pkg::CTM_ACT_LOW: pin_d = 1'b0;
        ctm_pkg::CTM_ACT_HIGH: pin_d = 1'b1;
        ctm_pkg::CTM_ACT_TOGGLE: pin_d = !pin_q;
        default: pin_d = pin_q;
      endcase
    end else if (is_pwm && ctrl0_q.timer_enable_bit) begin
      case (ctrl1_q.pin_action_select)
        2'b01: pin_d = ctrl1_q.output_initial_level;
        2'b10: pin_d = (pwm_act == ctrl1_q.output_initial_level);
        default: pin_d = !ctrl1_q.output_initial_level;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_q <= 1'b0;
      pin_out_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      pin_out_q <= pin_d ^ ctrl1_q.output_polarity;
    end
  end
  assign timer_output_pin_out = pin_out_q;
  assign timer_output_pin_inverted_out = !pin_out_q;

  AST_ENABLE_CLEARS: assert property (@(posedge mclk_in) disable iff (rst_in)
    en_rise |=> (cnt_q == ctm_pkg::CNT_ZERO))
    else $error("counter not cleared on enable rise");
  AST_COUNT_UP: assert property (@(posedge mclk_in) disable iff (rst_in)
    (adv && !clr_hit && !en_rise) |=> (cnt_q == $past(cnt_q) + ctm_pkg::CNT_ONE))
    else $error("counter did not increment");
  AST_PAUSE_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ctrl0_q.count_pause && !wr_ctrl0) [*2] |-> $stable(cnt_q))
    else $error("counter moved while paused");
  AST_OFF_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!ctrl0_q.timer_enable_bit && !en_rise) |=> (cnt_q == $past(cnt_q)))
    else $error("counter moved while off");
  AST_IRQ_A_MATCH: assert property (@(posedge mclk_in) disable iff (rst_in)
    (adv && cnt_inc == compare_a_value_q) |=> compare_a_flag_out)
    else $error("missing comparator a request");
  AST_IRQ_P_CLEAR: assert property (@(posedge mclk_in) disable iff (rst_in)
    (match_p && !is_pwm && !ctrl1_q.clear_source_select) |=> (compare_p_flag_out && cnt_q == ctm_pkg::CNT_ZERO))
    else $error("p match request and clear not together");
  AST_BUF_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (wr_in && addr_in == ctm_pkg::ADDR_CMPA_LO) |=> (hold_buf_q == $past(wdata_in) && $stable(compare_a_value_q)))
    else $error("low write did not go to buffer only");
  AST_HIGH_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (wr_in && addr_in == ctm_pkg::ADDR_CMPA_HI) |=> (compare_a_value_q == {$past(wdata_in), $past(hold_buf_q)}))
    else $error("high write did not commit pair");
  AST_READ_HIGH: assert property (@(posedge mclk_in) disable iff (rst_in)
    (rd_in && addr_in == ctm_pkg::ADDR_CNT_HI) |=> (rdata_out == $past(cnt_q[15:8]) && hold_buf_q == $past(cnt_q[7:0])))
    else $error("counter high read wrong");
  AST_CTRL0_RSVD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (rd_in && addr_in == ctm_pkg::ADDR_CTRL0) |=> (rdata_out[2:0] == ctm_pkg::RSVD_ZERO))
    else $error("reserved bits not zero");
  AST_PIN_INIT: assert property (@(posedge mclk_in) disable iff (rst_in)
    (en_rise && (ctrl1_q.operating_mode_select == ctm_pkg::CTM_MODE_CMP || is_pwm)) |=>
    (pin_q == $past(ctrl1_q.output_initial_level)))
    else $error("pin not returned to initial level");
  AST_PIN_HIGH: assert property (@(posedge mclk_in) disable iff (rst_in)
    (match_a && !en_rise && ctrl1_q.operating_mode_select == ctm_pkg::CTM_MODE_CMP &&
     ctrl1_q.pin_action_select == ctm_pkg::CTM_ACT_HIGH) |=> timer_output_pin_out == !$past(ctrl1_q.output_polarity))
    else $error("pin did not go high on match");
endmodule

// *** bench/ctm_top_tb.sv ***
module ctm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic sub_clk = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rdata_out;
  logic fa, fp, pin, pin_n;
  int errors = 0;
  int checked = 0;
  logic [15:0] rnd = 16'h6CB4;
  logic [7:0] lo, hi, n;
  logic exp_lvl, init, pol;
  int w;
  // register model: what software should read back, built from the write history
  logic [7:0] m_c0 = 8'h00;
  logic [7:0] m_c1 = 8'h00;
  logic [7:0] m_buf = 8'h00;
  logic [7:0] m_per = 8'h00;
  logic [15:0] m_cmpa = 16'h0000;
  int div [6] = '{4, 1, 16, 64, 10, 10};

  always #10 mclk_in = ~mclk_in;
  // subsidiary clock: 10 system cycles per rising edge, offset so it never lands on an edge
  initial begin
    #3;
    forever #100 sub_clk = ~sub_clk;
  end

  ctm_top u_ctm_top (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .subsidiary_clock_in(sub_clk), .rdata_out(rdata_out),
    .compare_a_flag_out(fa), .compare_p_flag_out(fp), .timer_output_pin_out(pin),
    .timer_output_pin_inverted_out(pin_n));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // count high is not modelled here and count low reads the buffer; callers pass the count high expectation
  function automatic logic [7:0] mreg(input logic [2:0] a);
    case (a)
      3'h0: return m_c0;
      3'h1: return m_c1;
      3'h2, 3'h4: return m_buf;
      3'h5: return m_cmpa[15:8];
      3'h6: return m_per;
      default: return 8'h00;
    endcase
  endfunction

  task automatic summarize;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] act);
    checked++;
    if (act !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic chk_num(input logic [15:0] exp, input logic [15:0] act);
    checked++;
    if (act !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    case (a)
      3'h0: m_c0 = {d[7:3], 3'h0};
      3'h1: m_c1 = d;
      3'h4: m_buf = d;
      3'h5: m_cmpa = {d, m_buf};
      3'h6: m_per = d;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    chk_byte(exp, rdata_out);
    if (a == 3'h5) m_buf = m_cmpa[7:0];
  endtask

  // cycles until the chosen flag is seen; bounded so a dead counter cannot hang the run
  task automatic wait_flag(input bit p, output int cnt);
    cnt = 0;
    // sampled mid-cycle so the registered flag is settled when looked at
    do begin
      @(negedge mclk_in);
      cnt++;
    end while ((p ? fp : fa) !== 1'b1 && cnt < 70000);
    if (cnt >= 70000) begin
      errors++;
      summarize();
    end
  endtask

  task automatic interval(input bit p, input int exp);
    int c;
    wait_flag(p, c);
    wait_flag(p, c);
    chk_num(16'(exp), 16'(c));
  endtask

  task automatic chk_pin(input logic lvl);
    chk_byte({6'h00, lvl, ~lvl}, {6'h00, pin, pin_n});
  endtask

  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    wr(3'h0, 8'hF7);
    rd(3'h0, mreg(3'h0));
    wr(3'h7, 8'h55);
    rd(3'h7, 8'h00);
    wr(3'h2, 8'hAA);
    wr(3'h3, 8'hAA);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h00);
    rnd = lfsr(rnd);
    lo = rnd[7:0];
    hi = rnd[15:8];
    wr(3'h4, lo);
    wr(3'h5, hi);
    rd(3'h5, mreg(3'h5));
    rd(3'h4, mreg(3'h4));
    wr(3'h4, ~lo);
    rd(3'h5, mreg(3'h5));
    rd(3'h4, mreg(3'h4));
    rd(3'h5, mreg(3'h5));
    rd(3'h2, mreg(3'h2));
    wr(3'h6, hi);
    rd(3'h6, mreg(3'h6));
    wr(3'h1, lo);
    rd(3'h1, mreg(3'h1));
    // clock sources: interval between A matches is divider times compare value
    rnd = lfsr(rnd);
    n = 8'h04 + {5'h00, rnd[2:0]};
    wr(3'h0, 8'h00);
    wr(3'h4, n);
    wr(3'h5, 8'h00);
    wr(3'h1, 8'hC1);
    for (int s = 0; s < 6; s++) begin
      wr(3'h0, {1'b0, 3'(s), 1'b1, 3'h0});
      interval(0, div[s] * n);
      wr(3'h0, 8'h00);
    end
    wr(3'h0, 8'h68);
    repeat (300) @(posedge mclk_in);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h00);
    // pause holds, disable keeps residue, enable edge clears
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hC0);
    wr(3'h6, 8'h00);
    wr(3'h0, 8'h18);
    repeat (37) @(posedge mclk_in);
    // a control write lands one edge after it is driven, so the count still moves on that edge
    wr(3'h0, 8'h98);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h27);
    repeat (20) @(posedge mclk_in);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h27);
    wr(3'h0, 8'h18);
    wr(3'h0, 8'h10);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h29);
    wr(3'h0, 8'h98);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h00);
    // period comparator on the upper byte, comparator A on the full count
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h40);
    wr(3'h5, 8'h00);
    for (int p = 1; p < 3; p++) begin
      wr(3'h6, 8'(p));
      wr(3'h0, 8'h18);
      interval(1, 256 * p);
      interval(0, 256 * p);
      wr(3'h0, 8'h00);
    end
    // compare-mode pin actions, initial level and polarity
    wr(3'h4, n);
    wr(3'h5, 8'h00);
    for (int act = 1; act < 4; act++) begin
      rnd = lfsr(rnd);
      init = (act == 1);
      pol = rnd[0];
      wr(3'h1, {2'b00, 2'(act), init, pol, 2'b01});
      for (int k = 0; k < 2; k++) begin
        wr(3'h0, 8'h18);
        repeat (2) @(posedge mclk_in);
        @(negedge mclk_in);
        chk_pin(init ^ pol);
        exp_lvl = init;
        for (int m = 0; m < 2; m++) begin
          wait_flag(0, w);
          @(negedge mclk_in);
          exp_lvl = (act == 1) ? 1'b0 : (act == 2) ? 1'b1 : ~exp_lvl;
          chk_pin(exp_lvl ^ pol);
        end
        wr(3'h0, 8'h10);
      end
    end
    // pwm: P sets the period even with clear select on A, A sets the duty, init bit is the active level
    wr(3'h6, 8'h01);
    wr(3'h1, {2'b10, 2'b10, 1'b1, pol, 2'b01});
    wr(3'h0, 8'h18);
    interval(1, 256);
    repeat (2) @(negedge mclk_in);
    chk_pin(~pol);
    repeat (20) @(negedge mclk_in);
    chk_pin(pol);
    summarize();
  end
endmodule
